// >>> hw/conv_spi_regs.v
// Serial register bank with soft reset controls, identification and interrupt enables.
`timescale 1ns/1ps
// Function
// - Writing one to primary reset bit starts a soft reset of device logic.
// - Primary reset bit clears itself when the soft reset has completed.
// - Writing one to config B bit 2 pulses secondary reset line one, self-clearing.
// - Writing one to config B bit 1 pulses secondary reset line zero, self-clearing.
// - Enable bit 4 gates the sysref jitter event onto the interrupt.
// - Enable bit 3 gates the receiver data-valid low event onto the interrupt.
// - Enable bit 2 gates lane FIFO overflow or underflow onto the interrupt.
// - Bit order select zero shifts MSB first, one shifts LSB first.
// - Status flags clear on writing one; writing zero leaves them unchanged.
`include "conv_spi_regs_map.vh"

module conv_spi_regs #(
  parameter [7:0] CHIP_KIND_VALUE = 8'h5A,  // Arbitrary identification value.
  parameter [7:0] PRODUCT_ID_LOW  = 8'h34,  // Arbitrary identification value.
  parameter [7:0] PRODUCT_ID_HIGH = 8'h12,  // Arbitrary identification value.
  parameter [3:0] PRODUCT_GRADE   = 4'h1,   // Arbitrary identification value.
  parameter [3:0] SILICON_REV     = 4'h2    // Arbitrary identification value.
) (
  input  wire core_clk,
  input  wire resetn,
  input  wire spi_sclk,
  input  wire spi_cs_n,
  input  wire spi_sdi,
  output reg  spi_sdo,
  output reg  spi_sdo_oe,
  input  wire sysref_jitter_event,
  input  wire link_receiver_data_valid,
  input  wire lane_fifo_error,
  output reg  irq,
  output reg  device_soft_reset,
  output reg  secondary_reset_line_one,
  output reg  secondary_reset_line_zero
);

  // ===========================================================================
  // Reset release
  reg        rst_meta;
  reg        rst_sync;

  // Asynchronous assertion, release through two flip-flops.
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ===========================================================================
  // Register storage
  reg  [3:0] cfg_a;
  reg  [4:0] cfg_b_hi;
  reg  [2:0] irq_enable;
  reg  [2:0] irq_status;
  reg  [2:0] sr_cnt;
  reg        data_valid_prev;

  // ===========================================================================
  // Serial shifter
  reg        sclk_prev;
  reg [15:0] shift_in;
  reg  [3:0] bit_cnt;
  reg        in_data;
  reg        rd_mode;
  reg        blocked;
  reg [14:0] addr;
  reg  [7:0] tx_byte;

  wire       lsb_first = cfg_a[`CFGA_BIT_ORDER];
  wire       sclk_rise = ~spi_cs_n & spi_sclk & ~sclk_prev;
  wire       sclk_fall = ~spi_cs_n & ~spi_sclk & sclk_prev;
  wire [15:0] raw_word = {shift_in[14:0], spi_sdi};
  wire       instr_done = sclk_rise & ~in_data & (bit_cnt == 4'hF);
  wire       byte_done  = sclk_rise & in_data & (bit_cnt == 4'h7);

  // Bit reversal for LSB-first framing.
  reg [15:0] instr_word;
  reg  [7:0] data_byte;
  reg  [7:0] rd_data;
  reg  [7:0] tx_load;
  reg [14:0] load_addr;
  integer    i;

  // Orders the received instruction and data byte per the bit order select.
  always @* begin
    instr_word = raw_word;
    data_byte  = raw_word[7:0];
    tx_load    = rd_data;
    if (lsb_first) begin
      for (i = 0; i < 16; i = i + 1) begin
        instr_word[i] = raw_word[15-i];
      end
      for (i = 0; i < 8; i = i + 1) begin
        data_byte[i] = raw_word[7-i];
        tx_load[i]   = rd_data[7-i];
      end
    end
  end

  // Address of the byte loaded for readback: the new instruction or the next stream step.
  always @* begin
    if (instr_done) begin
      load_addr = instr_word[14:0];
    end else if (cfg_a[`CFGA_ADDR_ASCEND]) begin
      load_addr = addr + 15'h0001;
    end else begin
      load_addr = addr - 15'h0001;
    end
  end

  // Read data decode.
  always @* begin
    if (load_addr == `ADDR_INTERFACE_CONFIG_A) begin
      rd_data = {cfg_a[0], cfg_a[1], cfg_a[2], cfg_a[3], cfg_a};
    end else if (load_addr == `ADDR_INTERFACE_CONFIG_B) begin
      rd_data = {cfg_b_hi, secondary_reset_line_one, secondary_reset_line_zero, 1'b0};
    end else if (load_addr == `ADDR_CHIP_KIND) begin
      rd_data = CHIP_KIND_VALUE;
    end else if (load_addr == `ADDR_PRODUCT_ID_LOW) begin
      rd_data = PRODUCT_ID_LOW;
    end else if (load_addr == `ADDR_PRODUCT_ID_HIGH) begin
      rd_data = PRODUCT_ID_HIGH;
    end else if (load_addr == `ADDR_GRADE_AND_REVISION) begin
      rd_data = {PRODUCT_GRADE, SILICON_REV};
    end else if (load_addr == `ADDR_INTERRUPT_ENABLE) begin
      rd_data = {3'h0, irq_enable, 2'h0};
    end else if (load_addr == `ADDR_INTERRUPT_STATUS) begin
      rd_data = {3'h0, irq_status, 2'h0};
    end else begin
      rd_data = 8'h00;
    end
  end

  // Write strobe: a completed data byte of a write stream that is not blocked.
  wire       wr_stb = byte_done & ~rd_mode & ~blocked;

  // Frame sequencing: instruction, then data bytes with readback shifted out on falling edges.
  always @(posedge core_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      sclk_prev  <= 1'b0;
      shift_in   <= 16'h0000;
      bit_cnt    <= 4'h0;
      in_data    <= 1'b0;
      rd_mode    <= 1'b0;
      blocked    <= 1'b0;
      addr       <= 15'h0000;
      tx_byte    <= 8'h00;
      spi_sdo    <= 1'b0;
      spi_sdo_oe <= 1'b0;
    end else begin
      sclk_prev <= spi_sclk;
      if (spi_cs_n) begin
        bit_cnt    <= 4'h0;
        in_data    <= 1'b0;
        blocked    <= 1'b0;
        spi_sdo_oe <= 1'b0;
      end else begin
        if (sclk_rise) begin
          shift_in <= raw_word;
          bit_cnt  <= bit_cnt + 4'h1;
        end
        if (instr_done) begin
          in_data <= 1'b1;
          rd_mode <= instr_word[15];
          addr    <= load_addr;
          bit_cnt <= 4'h0;
          tx_byte <= tx_load;
        end else if (byte_done) begin
          addr    <= load_addr;
          bit_cnt <= 4'h0;
          tx_byte <= tx_load;
          if (cfg_b_hi[`CFGB_SINGLE_TRANSFER-3]) begin
            blocked <= 1'b1;
          end
        end
        if (sclk_fall & in_data & rd_mode & ~blocked) begin
          spi_sdo    <= tx_byte[7];
          tx_byte    <= {tx_byte[6:0], 1'b0};
          spi_sdo_oe <= 1'b1;
        end
      end
    end
  end

  // ===========================================================================
  // Soft resets and configuration registers
  wire       soft_active = device_soft_reset;

  // Soft reset length in cycles, cut to the counter width on purpose.
  localparam integer SOFT_LEN = `SOFT_RESET_CYCLES;

  // Primary soft reset sequencing and interface config A.
  always @(posedge core_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      cfg_a             <= `RESET_CONFIG_A;
      sr_cnt            <= 3'h0;
      device_soft_reset <= 1'b0;
    end else if (soft_active) begin
      if (sr_cnt == 3'h1) begin
        device_soft_reset             <= 1'b0;
        cfg_a[`CFGA_PRIMARY_RESET]    <= 1'b0;
      end
      sr_cnt <= sr_cnt - 3'h1;
    end else if (wr_stb && addr == `ADDR_INTERFACE_CONFIG_A) begin
      cfg_a <= data_byte[3:0];
      if (data_byte[`CFGA_PRIMARY_RESET]) begin
        device_soft_reset <= 1'b1;
        sr_cnt            <= SOFT_LEN[2:0];
      end
    end
  end

  // Interface config B with one-cycle secondary reset pulses.
  always @(posedge core_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      cfg_b_hi                  <= `RESET_CONFIG_B;
      secondary_reset_line_one  <= 1'b0;
      secondary_reset_line_zero <= 1'b0;
    end else begin
      secondary_reset_line_one  <= 1'b0;
      secondary_reset_line_zero <= 1'b0;
      if (soft_active) begin
        cfg_b_hi <= `RESET_CONFIG_B;
      end else if (wr_stb && addr == `ADDR_INTERFACE_CONFIG_B) begin
        cfg_b_hi                  <= data_byte[7:3];
        secondary_reset_line_one  <= data_byte[`CFGB_SECONDARY_ONE];
        secondary_reset_line_zero <= data_byte[`CFGB_SECONDARY_ZERO];
      end
    end
  end

  // ===========================================================================
  // Interrupt enables, sticky status and interrupt output
  wire [2:0] events = {sysref_jitter_event,
                       data_valid_prev & ~link_receiver_data_valid,
                       lane_fifo_error};
  wire [2:0] w1c = (wr_stb && addr == `ADDR_INTERRUPT_STATUS) ? data_byte[4:2] : 3'h0;

  // Events set flags whatever the enables say; a set in the clearing cycle wins.
  always @(posedge core_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      irq_enable      <= `RESET_IRQ_BITS;
      irq_status      <= `RESET_IRQ_BITS;
      data_valid_prev <= 1'b1;
      irq             <= 1'b0;
    end else begin
      data_valid_prev <= link_receiver_data_valid;
      if (soft_active) begin
        irq_enable <= `RESET_IRQ_BITS;
        irq_status <= `RESET_IRQ_BITS;
        irq        <= 1'b0;
      end else begin
        if (wr_stb && addr == `ADDR_INTERRUPT_ENABLE) begin
          irq_enable <= data_byte[4:2];
        end
        irq_status <= (irq_status & ~w1c) | events;
        irq        <= |(irq_status & irq_enable);
      end
    end
  end

endmodule // conv_spi_regs

// >>> hw/conv_spi_regs_map.vh
// Register offsets, field positions, reset values and timing counts of the serial register bank.
`ifndef CONV_SPI_REGS_MAP_VH
`define CONV_SPI_REGS_MAP_VH

// =============================================================================
// Register offsets (15-bit serial addresses).
`define ADDR_INTERFACE_CONFIG_A   15'h0000
`define ADDR_INTERFACE_CONFIG_B   15'h0001
`define ADDR_CHIP_KIND            15'h0003
`define ADDR_PRODUCT_ID_LOW       15'h0004
`define ADDR_PRODUCT_ID_HIGH      15'h0005
`define ADDR_GRADE_AND_REVISION   15'h0006
`define ADDR_INTERRUPT_ENABLE     15'h0020
`define ADDR_INTERRUPT_STATUS     15'h0024

// =============================================================================
// Field positions of interface_config_a.
`define CFGA_PRIMARY_RESET        0
`define CFGA_BIT_ORDER            1
`define CFGA_ADDR_ASCEND          2
`define CFGA_SDO_ACTIVE           3

// Field positions of interface_config_b.
`define CFGB_SECONDARY_ZERO       1
`define CFGB_SECONDARY_ONE        2
`define CFGB_SELECT_STALL         6
`define CFGB_SINGLE_TRANSFER      7

// Field positions shared by interrupt_enable and interrupt_status.
`define IRQ_LANE_FIFO             2
`define IRQ_DATA_VALID_LOW        3
`define IRQ_SYSREF_JITTER         4

// =============================================================================
// Reset values.
`define RESET_CONFIG_A            4'h0
`define RESET_CONFIG_B            5'h00
`define RESET_IRQ_BITS            3'h0

// =============================================================================
// Timing: length of the primary soft reset, in ns and in 100 ns clock cycles.
`define CLK_PERIOD_NS             100
`define SOFT_RESET_NS             500
`define SOFT_RESET_CYCLES         ((`SOFT_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> bench/conv_spi_regs_checker.sv
// Port assertions for the serial register bank.
`timescale 1ns/1ps
// =============================================================================
// Checker module.
module conv_spi_regs_checker (
  input wire core_clk,
  input wire resetn,
  input wire spi_sclk,
  input wire spi_cs_n,
  input wire spi_sdi,
  input wire spi_sdo,
  input wire spi_sdo_oe,
  input wire sysref_jitter_event,
  input wire link_receiver_data_valid,
  input wire lane_fifo_error,
  input wire irq,
  input wire device_soft_reset,
  input wire secondary_reset_line_one,
  input wire secondary_reset_line_zero
);
  // All checks run on the core clock and pause while reset is low.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  AST_SOFT_LEN: assert property (
    $rose(device_soft_reset) |-> device_soft_reset[*5] ##1 !device_soft_reset)
    else $error("soft reset length wrong");
  AST_SOFT_CAUSE: assert property (
    $rose(device_soft_reset) |-> !$past(spi_cs_n)) else $error("soft reset outside frame");
  AST_SEC_ONE: assert property (
    secondary_reset_line_one |-> !$past(spi_cs_n) ##1 !secondary_reset_line_one)
    else $error("line one pulse wrong");
  AST_SEC_ZERO: assert property (
    secondary_reset_line_zero |-> !$past(spi_cs_n) ##1 !secondary_reset_line_zero)
    else $error("line zero pulse wrong");
  AST_IRQ_SOFT: assert property (
    device_soft_reset[*3] |-> !irq) else $error("irq held in soft reset");
  AST_OE_IDLE: assert property (
    spi_cs_n[*3] |-> !spi_sdo_oe) else $error("sdo driven while idle");
  AST_OE_FRAME: assert property (
    $rose(spi_sdo_oe) |-> !spi_cs_n && !spi_sclk) else $error("sdo enable at wrong time");
  AST_IRQ_FALL: assert property (
    $fell(irq) |-> device_soft_reset || $past(device_soft_reset) || !$past(spi_cs_n, 2))
    else $error("irq fell without clear");
  AST_IRQ_RISE: assert property (
    $rose(irq) |-> $past(sysref_jitter_event, 2) || $past(lane_fifo_error, 2)
      || !$past(link_receiver_data_valid, 2) || !$past(spi_cs_n, 2))
    else $error("irq rose without cause");
endmodule // conv_spi_regs_checker

bind conv_spi_regs conv_spi_regs_checker i_chk (.core_clk(core_clk), .resetn(resetn),
  .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
  .spi_sdo_oe(spi_sdo_oe), .sysref_jitter_event(sysref_jitter_event),
  .link_receiver_data_valid(link_receiver_data_valid), .lane_fifo_error(lane_fifo_error),
  .irq(irq), .device_soft_reset(device_soft_reset),
  .secondary_reset_line_one(secondary_reset_line_one),
  .secondary_reset_line_zero(secondary_reset_line_zero));

// >>> bench/spi_host.sv
// Behavioural serial host that sends frames to the register bank.
`timescale 1ns/1ps
// =============================================================================
// Host model.
module spi_host (
  input  wire  core_clk,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_sdi,
  input  wire  spi_sdo
);
  // Idle bus: serial clock low, select high.
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi = 1'b0;
  end
  // One bit; each clock phase spans several core cycles, sdo is taken before the rise.
  task automatic bit_io(input logic b, output logic r);
    spi_sdi = b;
    repeat (4) @(negedge core_clk);
    r = spi_sdo;
    spi_sclk = 1'b1;
    repeat (3) @(negedge core_clk);
    spi_sclk = 1'b0;
  endtask
  // A 16-bit instruction and one data byte.
  task automatic frame(input logic rd, input logic [14:0] a, input logic [7:0] d,
                       input logic lsb, output logic [7:0] q);
    logic [23:0] w;
    logic r;
    integer i;
    w = {rd, a, d};
    @(negedge core_clk);
    spi_cs_n = 1'b0;
    for (i = 0; i < 24; i++) begin
      bit_io(lsb ? w[i < 16 ? 8 + i : i - 16] : w[23 - i], r);
      if (i >= 16) q[lsb ? i - 16 : 23 - i] = r;
    end
    repeat (3) @(negedge core_clk);
    spi_cs_n = 1'b1;
    spi_sdi = ~spi_sdi; // The released line shows no stale level.
    repeat (3) @(negedge core_clk);
  endtask
  // A 16-bit instruction and two streamed data bytes, MSB first.
  task automatic stream(input logic rd, input logic [14:0] a, input logic [15:0] d,
                        output logic [15:0] q);
    logic [31:0] w;
    logic r;
    integer i;
    w = {rd, a, d};
    @(negedge core_clk);
    spi_cs_n = 1'b0;
    for (i = 0; i < 32; i++) begin
      bit_io(w[31 - i], r);
      if (i >= 16) q[31 - i] = r;
    end
    repeat (3) @(negedge core_clk);
    spi_cs_n = 1'b1;
    repeat (3) @(negedge core_clk);
  endtask
endmodule // spi_host

// >>> bench/tb.sv
// Self-checking bench of the serial register bank.
`timescale 1ns/1ps
`include "conv_spi_regs_map.vh"
// =============================================================================
// Bench top.
module tb;
  localparam [7:0] CK = 8'hA7, PL = 8'h3C, PH = 8'h81; // Arbitrary identification values.
  localparam [3:0] GR = 4'h6, RV = 4'h9; // Arbitrary identification values.
  logic core_clk = 0, resetn = 0, ev_jit = 0, ev_dv = 1, ev_fifo = 0;
  wire sclk, cs_n, sdi, sdo, oe, irq, sr, s1, s0;
  wire sdo_line = oe ? sdo : ~sdo; // A released line shows the inverse of its last level.
  integer error_cnt = 0, num_checks = 0, n1 = 0, n0 = 0, nsr = 0, i;
  logic [7:0] q;
  logic [15:0] q2;
  logic [31:0] rows [0:13];
  always #50 core_clk = ~core_clk;
  conv_spi_regs #(.CHIP_KIND_VALUE(CK), .PRODUCT_ID_LOW(PL), .PRODUCT_ID_HIGH(PH),
    .PRODUCT_GRADE(GR), .SILICON_REV(RV)) i_dut (.core_clk(core_clk), .resetn(resetn),
    .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(oe),
    .sysref_jitter_event(ev_jit), .link_receiver_data_valid(ev_dv),
    .lane_fifo_error(ev_fifo), .irq(irq), .device_soft_reset(sr),
    .secondary_reset_line_one(s1), .secondary_reset_line_zero(s0));
  spi_host i_host (.core_clk(core_clk), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_sdi(sdi),
    .spi_sdo(sdo_line));
  // Counts the cycles each reset output is high.
  always @(posedge core_clk) begin
    n1 <= n1 + s1;
    n0 <= n0 + s0;
    nsr <= nsr + sr;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [14:0] a, input logic [7:0] e, input logic l);
    i_host.frame(1'b1, a, 8'h00, l, q);
    chk(q, e);
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d, input logic l);
    i_host.frame(1'b0, a, d, l, q);
  endtask
  task automatic do_reset;
    resetn = 1'b0;
    repeat (4) @(negedge core_clk);
    resetn = 1'b1;
    repeat (3) @(negedge core_clk);
  endtask
  // Raises one event input for two cycles; bit 3 is a fall of the data-valid level.
  task automatic fire(input integer b);
    @(negedge core_clk);
    if (b == 4) ev_jit = 1'b1; else if (b == 3) ev_dv = 1'b0; else ev_fifo = 1'b1;
    repeat (2) @(negedge core_clk);
    ev_jit = 1'b0;
    ev_fifo = 1'b0;
    ev_dv = 1'b1;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic close_out;
    $display("Checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Watchdog against a hung serial frame.
  initial begin
    #5_000_000;
    error_cnt++;
    $display("MISMATCH %0t watchdog expired", $time);
    close_out;
  end
  // Main sequence: row table first, then hand-written cases.
  initial begin
    rows = '{{1'b1, `ADDR_CHIP_KIND, 8'h00, CK}, {1'b1, `ADDR_PRODUCT_ID_LOW, 8'h00, PL},
      {1'b1, `ADDR_PRODUCT_ID_HIGH, 8'h00, PH}, {1'b1, `ADDR_GRADE_AND_REVISION, 8'h00, GR, RV},
      {1'b1, `ADDR_INTERFACE_CONFIG_B, 16'h0000}, {1'b1, `ADDR_INTERRUPT_ENABLE, 16'h0000},
      {1'b1, 15'h0010, 16'h0000}, {1'b0, `ADDR_CHIP_KIND, 16'hFF00},
      {1'b1, `ADDR_CHIP_KIND, 8'h00, CK}, {1'b0, `ADDR_INTERRUPT_ENABLE, 16'h1C00},
      {1'b1, `ADDR_INTERRUPT_ENABLE, 16'h001C}, {1'b0, `ADDR_INTERFACE_CONFIG_B, 16'h7800},
      {1'b1, `ADDR_INTERFACE_CONFIG_B, 16'h0078}, {1'b0, `ADDR_INTERFACE_CONFIG_B, 16'h0000}};
    do_reset;
    chk({3'h0, irq, sr, s1, s0, oe}, 8'h00);
    for (i = 0; i < 14; i++) begin
      if (rows[i][31]) rd(rows[i][30:16], rows[i][7:0], 1'b0);
      else wr(rows[i][30:16], rows[i][15:8], 1'b0);
    end
    // Streaming reads step down by default and up with the ascend bit set.
    i_host.stream(1'b1, `ADDR_PRODUCT_ID_HIGH, 16'h0000, q2);
    chk(q2[15:8], PH);
    chk(q2[7:0], PL);
    wr(`ADDR_INTERFACE_CONFIG_A, 8'h04, 1'b0);
    i_host.stream(1'b1, `ADDR_PRODUCT_ID_LOW, 16'h0000, q2);
    chk(q2[15:8], PL);
    chk(q2[7:0], PH);
    wr(`ADDR_INTERFACE_CONFIG_A, 8'h00, 1'b0);
    // With single transfers the second byte must not land in config A.
    wr(`ADDR_INTERFACE_CONFIG_B, 8'h80, 1'b0);
    i_host.stream(1'b0, `ADDR_INTERFACE_CONFIG_B, 16'h8004, q2);
    rd(`ADDR_INTERFACE_CONFIG_A, 8'h00, 1'b0);
    rd(`ADDR_INTERFACE_CONFIG_B, 8'h80, 1'b0);
    wr(`ADDR_INTERFACE_CONFIG_B, 8'h00, 1'b0);
    // Each secondary line answers only to its own bit.
    wr(`ADDR_INTERFACE_CONFIG_B, 8'h04, 1'b0);
    chk(n1[7:0], 8'h01);
    chk(n0[7:0], 8'h00);
    wr(`ADDR_INTERFACE_CONFIG_B, 8'h02, 1'b0);
    chk(n1[7:0], 8'h01);
    chk(n0[7:0], 8'h01);
    wr(`ADDR_INTERFACE_CONFIG_B, 8'h06, 1'b0);
    chk(n1[7:0], 8'h02);
    chk(n0[7:0], 8'h02);
    rd(`ADDR_INTERFACE_CONFIG_B, 8'h00, 1'b0);
    for (i = 2; i <= 4; i++) begin
      wr(`ADDR_INTERRUPT_ENABLE, 8'h00, 1'b0);
      fire(i);
      chk({7'h00, irq}, 8'h00);
      rd(`ADDR_INTERRUPT_STATUS, 8'(1 << i), 1'b0);
      wr(`ADDR_INTERRUPT_ENABLE, 8'(1 << i), 1'b0);
      repeat (3) @(negedge core_clk);
      chk({7'h00, irq}, 8'h01);
      wr(`ADDR_INTERRUPT_STATUS, 8'h00, 1'b0);
      rd(`ADDR_INTERRUPT_STATUS, 8'(1 << i), 1'b0);
      wr(`ADDR_INTERRUPT_STATUS, 8'(1 << i), 1'b0);
      chk({7'h00, irq}, 8'h00);
    end
    wr(`ADDR_INTERFACE_CONFIG_A, 8'h02, 1'b0);
    rd(`ADDR_CHIP_KIND, CK, 1'b1);
    rd(`ADDR_INTERFACE_CONFIG_A, 8'h42, 1'b1);
    wr(`ADDR_INTERFACE_CONFIG_A, 8'h00, 1'b1);
    rd(`ADDR_PRODUCT_ID_LOW, PL, 1'b0);
    wr(`ADDR_INTERRUPT_ENABLE, 8'h1C, 1'b0);
    wr(`ADDR_INTERFACE_CONFIG_A, 8'h01, 1'b0);
    repeat (10) @(negedge core_clk);
    chk(nsr[7:0], 8'h05);
    rd(`ADDR_INTERFACE_CONFIG_A, 8'h00, 1'b0);
    rd(`ADDR_INTERRUPT_ENABLE, 8'h00, 1'b0);
    wr(`ADDR_INTERRUPT_ENABLE, 8'h14, 1'b0);
    do_reset;
    rd(`ADDR_INTERRUPT_ENABLE, 8'h00, 1'b0);
    close_out;
  end
endmodule // tb
